//--- rtl/insn_decode_params.svh
// Constants of the instruction word decoder
`ifndef INSN_DECODE_PARAMS_SVH
`define INSN_DECODE_PARAMS_SVH
`define WORD_W 24
`define F_OP 23:16
`define F_OP_VAR 16
`define F_SIZE 15:14
`define F_BASE 13:10
`define F_SRC 9:6
`define F_DEST 5:2
`define F_SRC_IND 1
`define F_DEST_IND 0
`define F_FDEST 13
`define F_FADDR 12:0
`define F_BITSEL 15:12
`define F_BIT_BASE 11:8
`define F_BIT_IND 4
`define F_BIT_REG 3:0
`define F_BIT_FIDX 11:0
`define F_LIT 13:4
`define F_LDEST 3:0
`define F_ACC 15
`define F_MPAIR 14:12
`define F_XPF 11:9
`define F_YPF 8:6
`define F_XD 5:4
`define F_YD 3:2
`define F_WBACK 1:0
`define F_SH_REG 14
`define F_SHIFT 13:8
`define F_WSO 7:4
`define F_WSO_IND 3
`define F_TGT_LO 15:0
`define F_TGT_HI 6:0
`define OP_NOP 8'h00
`define OP_GOTO2 8'h01
`define OP_CALL2 8'h02
`define OP_MOVD2 8'h03
`define OP_JUMP 8'h04
`define OP_INDIR 8'h05
`define OP_RETURN 8'h06
`define OP_IRET 8'h07
`define OP_TBLRD 8'h08
`define OP_TBLWR 8'h09
`define OP_CONDJ 8'h0A
`define OP_SKIP 8'h0B
`define GRP_CTRL 4'h0
`define GRP_REGOP 4'h1
`define GRP_FILE 4'h2
`define GRP_LIT 4'h3
`define GRP_BITW 4'h4
`define GRP_BITF 4'h5
`define GRP_MAC 4'h6
`define GRP_DSP 4'h7
`define SZ_WORD 2'h0
`define SZ_BYTE 2'h1
`define SZ_DWORD 2'h2
`define WB_NONE 2'h0
`define WB_REG 2'h1
`define WB_PINC 2'h2
`define WB_BAD 2'h3
`define WB_TARGET_REG 4'hD
`define W0_NUM 4'h0
`define LIT_BYTE_MAX 10'h0FF
`define CYC_1 2'h1
`define CYC_2 2'h2
`define CYC_3 2'h3
`define CYC_TABLE 2'h2
`define CYC_RETURN 2'h3
`endif

//--- rtl/insn_decode_pkg.sv
// Types shared by the instruction word decoder files
package insn_decode_pkg;
  typedef enum logic [3:0] {
    cls_nop, cls_two_word, cls_jump, cls_indirect, cls_table, cls_return,
    cls_cond, cls_skip, cls_regop, cls_file, cls_lit, cls_bit_w, cls_bit_f,
    cls_mac, cls_dsp, cls_illegal
  } insn_class_t;
  typedef enum logic [1:0] {st_first, st_second, st_stall} dec_state_t;
  typedef struct packed {
    logic carry;
    logic half_byte_carry;
    logic negative;
    logic signed_range_exceeded;
    logic zero;
  } mcu_flags_t;
  typedef struct packed {
    logic accum_a_overflow;
    logic accum_b_overflow;
    logic accum_a_clipped;
    logic accum_b_clipped;
  } dsp_flags_t;
  typedef struct packed {
    mcu_flags_t mcu;
    dsp_flags_t dsp;
  } flag_set_t;
  typedef struct packed {
    insn_class_t cls;
    logic [7:0] opcode;
    logic [1:0] size;
    logic [3:0] base_operand_reg;
    logic [3:0] source_operand_reg;
    logic src_ind;
    logic [3:0] dest_operand_reg;
    logic dest_ind;
    logic [12:0] file_addr;
    logic to_file_op_default_reg;
    logic [3:0] bit_select_field;
    logic bit_by_base;
    logic [9:0] ten_bit_literal;
    logic acc_b;
    logic [2:0] mul_pair;
    logic [2:0] x_pf;
    logic [2:0] y_pf;
    logic [1:0] x_dst;
    logic [1:0] y_dst;
    logic wback_en;
    logic [3:0] accum_writeback_reg;
    logic wback_ind;
    logic shift_by_reg;
    logic [5:0] shift;
    logic [22:0] target;
  } decoded_t;
  typedef struct packed {
    dec_state_t st;
    logic [23:0] first_word;
    logic [1:0] stall_cnt;
    logic stall;
    logic issue;
    logic nop_slot;
    decoded_t dec;
    logic [1:0] cycles;
    logic [1:0] advance;
    logic illegal;
    logic second_err;
    logic lit_err;
    flag_set_t mask;
  } core_state_t;
endpackage : insn_decode_pkg

//--- rtl/instruction_word_decode_timing.sv
// Instruction word decoder: operand split, word count and cycle cost
`timescale 1ns/1ps
`include "insn_decode_params.svh"
module instruction_word_decode_timing
  import insn_decode_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [23:0] fetch_word_i,
  input wire logic fetch_valid_i,
  input wire logic [23:0] peek_word_i,
  input wire logic cond_true_i,
  input wire flag_set_t result_flags_i,
  output logic issue_o,
  output decoded_t decoded_o,
  output logic [1:0] cycles_o,
  output logic [1:0] word_advance_o,
  output logic fetch_stall_o,
  output logic nop_slot_o,
  output logic illegal_o,
  output logic second_word_err_o,
  output logic lit_range_err_o,
  output flag_set_t status_flags_o
);
  core_state_t s;
  core_state_t next_s;
  logic go;
  logic [23:0] w1;
  logic [23:0] w2;
  insn_class_t cls;
  logic [1:0] cost_v;

  // Opcode to instruction class
  function automatic insn_class_t classify(input logic [7:0] op);
    insn_class_t c;
    c = cls_illegal;
    if (op[7:4] == `GRP_CTRL) begin
      case (op)
        // lone second word is a no-operation
        `OP_NOP: c = cls_nop;
        `OP_GOTO2, `OP_CALL2, `OP_MOVD2: c = cls_two_word;
        `OP_JUMP: c = cls_jump;
        `OP_INDIR: c = cls_indirect;
        `OP_RETURN, `OP_IRET: c = cls_return;
        `OP_TBLRD, `OP_TBLWR: c = cls_table;
        `OP_CONDJ: c = cls_cond;
        `OP_SKIP: c = cls_skip;
        default: c = cls_illegal;
      endcase
    end else begin
      case (op[7:4])
        `GRP_REGOP: c = cls_regop;
        `GRP_FILE: c = cls_file;
        `GRP_LIT: c = cls_lit;
        `GRP_BITW: c = cls_bit_w;
        `GRP_BITF: c = cls_bit_f;
        `GRP_MAC: c = cls_mac;
        `GRP_DSP: c = cls_dsp;
        default: c = cls_illegal;
      endcase
    end
    return c;
  endfunction : classify

  function automatic logic two_word(input logic [7:0] op);
    return classify(op) == cls_two_word;
  endfunction : two_word

  // Operand fields per class
  function automatic decoded_t split(input logic [23:0] a, input logic [23:0] b,
                                     input insn_class_t c);
    decoded_t d;
    d = '0;
    d.cls = c;
    d.opcode = a[`F_OP];
    d.size = (a[`F_SIZE] == `SZ_BYTE || a[`F_SIZE] == `SZ_DWORD) ? a[`F_SIZE] : `SZ_WORD;
    case (c)
      cls_regop: begin
        d.base_operand_reg = a[`F_BASE];
        d.source_operand_reg = a[`F_SRC];
        d.src_ind = a[`F_SRC_IND];
        d.dest_operand_reg = a[`F_DEST];
        d.dest_ind = a[`F_DEST_IND];
      end
      cls_file: begin
        d.file_addr = a[`F_FADDR];
        d.to_file_op_default_reg = a[`F_FDEST];
        d.dest_operand_reg = `W0_NUM;
      end
      cls_lit: begin
        d.ten_bit_literal = a[`F_LIT];
        d.dest_operand_reg = a[`F_LDEST];
      end
      // bit select by literal or base
      cls_bit_w, cls_skip: begin
        d.bit_select_field = a[`F_BITSEL];
        d.bit_by_base = a[`F_OP_VAR];
        d.base_operand_reg = a[`F_BIT_BASE];
        d.source_operand_reg = a[`F_BIT_REG];
        d.src_ind = a[`F_BIT_IND];
      end
      cls_bit_f: begin
        d.bit_select_field = a[`F_BITSEL];
        d.bit_by_base = a[`F_OP_VAR];
        d.file_addr = {a[`F_BIT_FIDX], 1'b0};
      end
      cls_mac: begin
        d.acc_b = a[`F_ACC];
        d.mul_pair = a[`F_MPAIR];
        d.x_pf = a[`F_XPF];
        d.y_pf = a[`F_YPF];
        d.x_dst = a[`F_XD];
        d.y_dst = a[`F_YD];
        d.wback_en = a[`F_WBACK] == `WB_REG || a[`F_WBACK] == `WB_PINC;
        d.accum_writeback_reg = d.wback_en ? `WB_TARGET_REG : `W0_NUM;
        d.wback_ind = a[`F_WBACK] == `WB_PINC;
      end
      cls_dsp: begin
        d.acc_b = a[`F_ACC];
        d.shift_by_reg = a[`F_SH_REG];
        d.shift = a[`F_SHIFT];
        d.source_operand_reg = a[`F_WSO];
        d.src_ind = a[`F_WSO_IND];
      end
      default: begin
        d.target = {b[`F_TGT_HI], a[`F_TGT_LO]};
      end
    endcase
    return d;
  endfunction : split

  // Cycle cost of one instruction
  function automatic logic [1:0] cost(input insn_class_t c, input logic [1:0] sz,
                                      input logic cnd, input logic skip2);
    logic [1:0] n;
    n = `CYC_1;
    case (c)
      cls_jump, cls_indirect, cls_table: n = `CYC_TABLE;
      cls_return: n = `CYC_RETURN;
      cls_cond: n = cnd ? `CYC_2 : `CYC_1;
      // skip over one or two words
      cls_skip: n = cnd ? (skip2 ? `CYC_3 : `CYC_2) : `CYC_1;
      cls_two_word: n = `CYC_2;
      cls_regop, cls_file: n = (sz == `SZ_DWORD) ? `CYC_2 : `CYC_1;
      default: n = `CYC_1;
    endcase
    return n;
  endfunction : cost

  // Flags each class may touch
  function automatic flag_set_t affect(input decoded_t d);
    flag_set_t m;
    m = '0;
    case (d.cls)
      cls_regop, cls_file, cls_lit: m.mcu = '1;
      cls_bit_w, cls_bit_f: m.mcu.zero = 1'b1;
      cls_mac, cls_dsp: begin
        m.dsp.accum_a_overflow = !d.acc_b;
        m.dsp.accum_a_clipped = !d.acc_b;
        m.dsp.accum_b_overflow = d.acc_b;
        m.dsp.accum_b_clipped = d.acc_b;
      end
      default: m = '0;
    endcase
    return m;
  endfunction : affect

  // Sequencing of words, issue and extra no-operation cycles
  always_comb begin
    next_s = s;
    next_s.issue = 1'b0;
    next_s.nop_slot = 1'b0;
    next_s.second_err = 1'b0;
    next_s.illegal = 1'b0;
    next_s.lit_err = 1'b0;
    next_s.mask = '0;
    go = 1'b0;
    w1 = fetch_word_i;
    w2 = '0;
    cls = classify(fetch_word_i[`F_OP]);
    cost_v = `CYC_1;
    case (s.st)
      st_first: begin
        if (fetch_valid_i) begin
          next_s.advance = two_word(fetch_word_i[`F_OP]) ? `CYC_2 : `CYC_1;
          if (cls == cls_two_word) begin
            next_s.first_word = fetch_word_i;
            next_s.st = st_second;
          end else begin
            go = 1'b1;
          end
        end
      end
      st_second: begin
        if (fetch_valid_i) begin
          w1 = s.first_word;
          w2 = fetch_word_i;
          cls = cls_two_word;
          go = 1'b1;
          next_s.second_err = fetch_word_i[`F_OP] != `OP_NOP;
        end
      end
      st_stall: begin
        next_s.nop_slot = 1'b1;
        next_s.stall_cnt = s.stall_cnt - 2'h1;
        if (s.stall_cnt == `CYC_1) begin
          next_s.st = st_first;
          next_s.stall = 1'b0;
        end
      end
      default: begin
        next_s.st = st_first;
        next_s.stall = 1'b0;
      end
    endcase
    if (go) begin
      next_s.issue = 1'b1;
      next_s.dec = split(w1, w2, cls);
      cost_v = cost(cls, next_s.dec.size, cond_true_i, two_word(peek_word_i[`F_OP]));
      next_s.cycles = cost_v;
      next_s.illegal = cls == cls_illegal || next_s.second_err
                       || (cls == cls_mac && w1[`F_WBACK] == `WB_BAD);
      next_s.lit_err = cls == cls_lit && next_s.dec.size == `SZ_BYTE
                       && w1[`F_LIT] > `LIT_BYTE_MAX;
      next_s.mask = (next_s.illegal || next_s.lit_err) ? '0 : affect(next_s.dec);
      if (cls != cls_two_word && cost_v != `CYC_1) begin
        next_s.st = st_stall;
        next_s.stall = 1'b1;
        next_s.stall_cnt = cost_v - 2'h1;
      end else begin
        next_s.st = st_first;
        next_s.stall = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  status_flag_bank u_flags (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .upd_mask_i(s.mask),
    .result_i(result_flags_i),
    .flags_o(status_flags_o)
  );

  assign issue_o = s.issue;
  assign decoded_o = s.dec;
  assign cycles_o = s.cycles;
  assign word_advance_o = s.advance;
  assign fetch_stall_o = s.stall;
  assign nop_slot_o = s.nop_slot;
  assign illegal_o = s.illegal;
  assign second_word_err_o = s.second_err;
  assign lit_range_err_o = s.lit_err;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_take_first;
    s.st == st_first && fetch_valid_i;
  endsequence
  sequence s_one_nop;
    fetch_stall_o && issue_o ##1 !fetch_stall_o && nop_slot_o;
  endsequence
  sequence s_two_nop;
    fetch_stall_o [*2] ##1 !fetch_stall_o;
  endsequence

  a_single_advance: assert property (
    s_take_first and !two_word(fetch_word_i[`F_OP]) |=> word_advance_o == `CYC_1 && issue_o)
    else $error("single word not issued with advance one");
  a_two_word_hold: assert property (
    s_take_first and two_word(fetch_word_i[`F_OP]) |=> !issue_o && word_advance_o == `CYC_2)
    else $error("two-word first half issued early");
  a_opcode_split: assert property (
    s_take_first and !two_word(fetch_word_i[`F_OP])
    |=> decoded_o.opcode == $past(fetch_word_i[`F_OP]))
    else $error("opcode field wrong");
  a_second_zero: assert property (
    (s.st == st_second && fetch_valid_i && fetch_word_i[`F_OP] != `OP_NOP)
    |=> second_word_err_o && illegal_o)
    else $error("bad second word not flagged");
  a_orphan_nop: assert property (
    s_take_first and fetch_word_i[`F_OP] == `OP_NOP
    |=> decoded_o.cls == cls_nop && cycles_o == `CYC_1 ##1 $stable(status_flags_o))
    else $error("lone second word not a no-operation");
  a_cond_cost: assert property (
    s_take_first and classify(fetch_word_i[`F_OP]) == cls_cond and cond_true_i
    |=> cycles_o == `CYC_2 ##0 s_one_nop)
    else $error("true condition not two cycles");
  a_return_cost: assert property (
    s_take_first and classify(fetch_word_i[`F_OP]) == cls_return |=> s_two_nop)
    else $error("return not three cycles");
  a_skip_cost: assert property (
    s_take_first and classify(fetch_word_i[`F_OP]) == cls_skip and cond_true_i
    and two_word(peek_word_i[`F_OP]) |=> cycles_o == `CYC_3 ##0 s_two_nop)
    else $error("skip over two words not three cycles");
  a_pair_cost: assert property (
    (s.st == st_second && fetch_valid_i) |=> issue_o && cycles_o == `CYC_2 && !fetch_stall_o)
    else $error("two-word instruction cost wrong");
  a_wback_limit: assert property (
    issue_o && decoded_o.wback_en |-> decoded_o.accum_writeback_reg == `WB_TARGET_REG)
    else $error("write-back not W13");
  a_lit_byte: assert property (
    lit_range_err_o |-> issue_o && decoded_o.size == `SZ_BYTE
    && decoded_o.ten_bit_literal > `LIT_BYTE_MAX && s.mask == '0)
    else $error("literal range error without cause");
endmodule : instruction_word_decode_timing

//--- rtl/status_flag_bank.sv
// General and accumulator status flags with per-bit update masks
`timescale 1ns/1ps
`include "insn_decode_params.svh"
module status_flag_bank
  import insn_decode_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire flag_set_t upd_mask_i,
  input wire flag_set_t result_i,
  output flag_set_t flags_o
);
  flag_set_t s;
  flag_set_t next_s;

  always_comb begin
    next_s = flag_set_t'((s & ~upd_mask_i) | (result_i & upd_mask_i));
  end

  // Flag register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flags_o = s;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_flag_unmasked_hold: assert property (
    1'b1 |=> ((s ^ $past(s)) & ~$past(upd_mask_i)) == '0)
    else $error("flag changed without update mask");
  a_flag_masked_load: assert property (
    upd_mask_i.mcu.zero |=> s.mcu.zero == $past(result_i.mcu.zero))
    else $error("zero flag not loaded");
  a_accum_flags_split: assert property (
    (!upd_mask_i.dsp.accum_b_overflow && !upd_mask_i.dsp.accum_b_clipped)
    |=> $stable(s.dsp.accum_b_overflow) && $stable(s.dsp.accum_b_clipped))
    else $error("accumulator B flags moved on A update");
endmodule : status_flag_bank

//--- verif/fetch_model.sv
// Program memory fetch model that feeds the decoder one word per taken edge
`timescale 1ns/1ps
module fetch_model (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wr_i,
  input wire logic [5:0] wr_addr_i,
  input wire logic [24:0] wr_data_i,
  input wire logic [6:0] len_i,
  input wire logic go_i,
  input wire logic gap_i,
  input wire logic stall_i,
  output logic [23:0] word_o,
  output logic valid_o,
  output logic [23:0] peek_o,
  output logic cond_o,
  output logic [6:0] pc_o
);
  logic [24:0] mem [0:63];
  logic [6:0] pc = 7'h00;
  logic [24:0] cur;

  // Blank memory so that peeks past the program read a defined word
  initial begin
    foreach (mem[i]) begin
      mem[i] = 25'h0000000;
    end
  end

  // Word and condition go out in order; a gap scrambles them so stale data never passes
  assign cur = mem[pc[5:0]];
  assign pc_o = pc;
  assign valid_o = go_i && !gap_i && (pc < len_i);
  assign word_o = valid_o ? cur[23:0] : ~cur[23:0];
  assign cond_o = valid_o ? cur[24] : ~cur[24];
  assign peek_o = mem[pc[5:0] + 6'h01][23:0];

  // Program loading and fetch pointer; words offered under stall are not consumed
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc <= 7'h00;
    end else begin
      if (wr_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      if (valid_o && !stall_i) begin
        pc <= pc + 7'h01;
      end
    end
  end
endmodule : fetch_model

//--- verif/instruction_word_decode_timing_tb_top.sv
// Self-checking bench for the instruction word decoder
`timescale 1ns/1ps
`include "insn_decode_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module instruction_word_decode_timing_tb_top
  import insn_decode_pkg::*;
;
  typedef struct {
    logic [1:0] cyc;
    logic [1:0] adv;
    logic [2:0] err;
    logic loose;
    insn_class_t cls;
    flag_set_t mask;
    logic [1:0] sel;
    logic [22:0] fv;
  } note_t;
  localparam logic [8:0] M_MCU = 9'h1F0;
  localparam logic [8:0] M_ZERO = 9'h010;
  localparam logic [8:0] M_ACCA = 9'h00A;
  localparam logic [8:0] M_ACCB = 9'h005;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [23:0] fetch_word_i, peek_word_i;
  logic fetch_valid_i, cond_true_i;
  logic wr = 1'b0;
  logic go = 1'b0;
  logic gap = 1'b0;
  flag_set_t result_flags_i = '0;
  logic issue_o, fetch_stall_o, nop_slot_o, illegal_o, second_word_err_o, lit_range_err_o;
  decoded_t decoded_o;
  logic [1:0] cycles_o, word_advance_o;
  flag_set_t status_flags_o;
  flag_set_t exp_flags = '0;
  logic [5:0] wa = 6'h00;
  logic [24:0] wd = 25'h0000000;
  logic [6:0] len = 7'h00;
  logic [6:0] pc;
  logic chk_flag = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  int seed = 32'hADD7F683;
  int nops = 0;
  int nops_exp = -1;
  logic [24:0] prog [$];
  note_t notes [$];
  note_t n;
  insn_class_t ctl [6] = '{cls_jump, cls_indirect, cls_return, cls_return, cls_table, cls_table};

  always #12.5 clk_sys_i = ~clk_sys_i;

  instruction_word_decode_timing u_dut (.clk_sys_i, .rst_b_i, .fetch_word_i, .fetch_valid_i,
    .peek_word_i, .cond_true_i, .result_flags_i, .issue_o, .decoded_o, .cycles_o,
    .word_advance_o, .fetch_stall_o, .nop_slot_o, .illegal_o, .second_word_err_o,
    .lit_range_err_o, .status_flags_o);
  fetch_model u_fetch (.clk_sys_i, .rst_b_i, .wr_i(wr), .wr_addr_i(wa), .wr_data_i(wd),
    .len_i(len), .go_i(go), .gap_i(gap), .stall_i(fetch_stall_o), .word_o(fetch_word_i),
    .valid_o(fetch_valid_i), .peek_o(peek_word_i), .cond_o(cond_true_i), .pc_o(pc));

  function automatic note_t mk(input logic [1:0] c, input insn_class_t k, input logic [8:0] m);
    mk = '{cyc: c, adv: 2'h1, err: 3'h0, loose: 1'b0, cls: k, mask: m, sel: 2'h0, fv: 23'h0};
  endfunction : mk

  // Program word plus, where an issue follows, its expected outcome
  task automatic put(input logic [24:0] w, input logic h, input note_t t);
    prog.push_back(w);
    if (h) begin
      notes.push_back(t);
    end
  endtask : put

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Random flag results and fetch gaps, driven just after each edge
  always @(posedge clk_sys_i) begin
    #1;
    result_flags_i = 9'($random(seed));
    gap = go && (($random(seed) & 3) == 0);
  end

  // Output watcher: each issue takes the oldest note and compares
  always @(negedge clk_sys_i) begin
    if (chk_flag) begin
      `CHK("flags", exp_flags, status_flags_o)
      chk_flag = 1'b0;
    end
    nops += (nop_slot_o === 1'b1);
    if (issue_o === 1'b1 && notes.size() == 0) begin
      `CHK("issue count", 1'b0, issue_o)
    end else if (issue_o === 1'b1) begin
      n = notes.pop_front();
      if (nops_exp >= 0) `CHK("nop slots", nops_exp, nops)
      if (n.err[0]) `CHK("lit error", 1'b1, lit_range_err_o)
      else `CHK("errors", n.err, {illegal_o, second_word_err_o, lit_range_err_o})
      if (!n.loose) begin
        `CHK("cycles", n.cyc, cycles_o)
        `CHK("advance", n.adv, word_advance_o)
        `CHK("class", n.cls, decoded_o.cls)
        `CHK("stall", n.cyc > 1 && n.cls != cls_two_word, fetch_stall_o)
        case (n.sel)
          2'h1: `CHK("literal", n.fv[9:0], decoded_o.ten_bit_literal)
          2'h2: `CHK("target", n.fv, decoded_o.target)
          2'h3: `CHK("operands", n.fv[5:0], n.cls == cls_mac ?
              {decoded_o.wback_en, decoded_o.accum_writeback_reg, decoded_o.wback_ind} :
              {decoded_o.size, decoded_o.dest_operand_reg})
          default: ;
        endcase
      end
      nops_exp = n.loose ? -1 : (n.cls == cls_two_word ? 0 : int'(n.cyc) - 1);
      nops = 0;
      exp_flags = (exp_flags & ~n.mask) | (result_flags_i & n.mask);
      chk_flag = 1'b1;
    end
  end

  // Main sequence: build program, reset, load, run, report
  initial begin
    logic [31:0] w;
    note_t t;
    put(25'h0000000, 1'b1, mk(2'h1, cls_nop, '0));
    for (int o = 4; o < 10; o++) begin
      w = $random(seed);
      t = mk((o == 6 || o == 7) ? `CYC_RETURN : 2'h2, ctl[o - 4], '0);
      put({1'b0, 8'(o), w[15:0]}, 1'b1, t);
    end
    for (int c = 0; c < 2; c++) begin
      put({c != 0, `OP_CONDJ, 16'h1234}, 1'b1, mk(2'(c + 1), cls_cond, '0));
    end
    // skip not taken, over one word, over two words
    for (int c = 0; c < 3; c++) begin
      put({c != 0, `OP_SKIP, 16'h0000}, 1'b1, mk(2'(c + 1), cls_skip, '0));
      if (c < 2) begin
        put(25'h0000000, 1'b1, mk(2'h1, cls_nop, '0));
      end
    end
    for (int o = 1; o < 4; o++) begin
      w = $random(seed);
      t = mk(2'h2, cls_two_word, '0);
      t.adv = 2'h2;
      t.sel = 2'h2;
      t.fv = w[22:0];
      put({1'b0, 8'(o), w[15:0]}, 1'b0, t);
      put({1'b0, 8'h00, 9'h000, w[22:16]}, 1'b1, t);
    end
    t = mk(2'h1, cls_illegal, '0);
    t.err = 3'b110;
    t.loose = 1'b1;
    put({1'b0, `OP_GOTO2, 16'h0000}, 1'b0, t);
    put(25'h0120000, 1'b1, t);
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      w[15:14] = 2'(i % 3);
      t = mk(w[15:14] == `SZ_DWORD ? 2'h2 : 2'h1, cls_regop, M_MCU);
      t.sel = 2'h3;
      t.fv = {17'h00000, w[15:14], w[5:2]};
      put({1'b0, 4'h1, w[19:0]}, 1'b1, t);
    end
    put({1'b0, 8'h20, `SZ_DWORD, 14'h2001}, 1'b1, mk(2'h2, cls_file, M_MCU));
    put({1'b0, 8'h2F, `SZ_BYTE, 14'h0123}, 1'b1, mk(2'h1, cls_file, M_MCU));
    t = mk(2'h1, cls_lit, M_MCU);
    t.sel = 2'h1;
    t.fv = 23'h0000FF;
    put({1'b0, 8'h30, `SZ_BYTE, 10'h0FF, 4'h3}, 1'b1, t);
    t.fv = 23'h0003FF;
    put({1'b0, 8'h30, `SZ_WORD, 10'h3FF, 4'h3}, 1'b1, t);
    t = mk(2'h1, cls_lit, '0);
    t.err = 3'b001;
    t.loose = 1'b1;
    put({1'b0, 8'h30, `SZ_BYTE, 10'h100, 4'h3}, 1'b1, t);
    put({1'b0, 8'h41, 16'hF3A5}, 1'b1, mk(2'h1, cls_bit_w, M_ZERO));
    put({1'b0, 8'h50, 16'h7123}, 1'b1, mk(2'h1, cls_bit_f, M_ZERO));
    for (int a = 1; a < 4; a++) begin
      t = mk(2'h1, cls_mac, a == 1 ? M_ACCA : M_ACCB);
      t.sel = 2'h3;
      t.fv = {17'h00000, 1'b1, `WB_TARGET_REG, a == 2};
      t.err = (a == 3) ? 3'b100 : 3'b000;
      t.loose = (a == 3);
      t.mask = (a == 3) ? 9'h000 : t.mask;
      put({1'b0, 8'h60, a != 1, 13'h0000, 2'(a)}, 1'b1, t);
    end
    // other DSP op on accumulator B
    put({1'b0, 8'h70, 16'hC000}, 1'b1, mk(2'h1, cls_dsp, M_ACCB));
    // Unmapped opcodes
    t = mk(2'h1, cls_illegal, '0);
    t.err = 3'b100;
    t.loose = 1'b1;
    put({1'b0, 8'h0C, 16'h0000}, 1'b1, t);
    put({1'b0, 8'h80, 16'h0000}, 1'b1, t);
    len = 7'(prog.size());
    prog.push_back(25'h0000000);
    repeat (10) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    `CHK("reset flags", 9'h000, status_flags_o)
    foreach (prog[i]) begin
      @(posedge clk_sys_i);
      #1;
      wr = 1'b1;
      wa = 6'(i);
      wd = prog[i];
    end
    @(posedge clk_sys_i);
    #1;
    wr = 1'b0;
    go = 1'b1;
    for (int k = 0; k < 3000 && !(pc == len && notes.size() == 0); k++) begin
      @(posedge clk_sys_i);
    end
    if (notes.size() != 0) `CHK("pending notes", 0, notes.size())
    repeat (6) @(posedge clk_sys_i);
    tally_and_finish();
  end
endmodule : instruction_word_decode_timing_tb_top
